// ---- logic/rtc_i2c_pkg.sv ----
// constants and state types shared by both ends of the clock's two-wire port
// assumes: a 20 MHz controller clock and a 1 Hz tick from the device timebase
package rtc_i2c_pkg;

	// ----------------------------------------------------------------
	// addressing
	// ----------------------------------------------------------------
	localparam logic [6:0] TARGET_ADDR  = 7'h51;
	localparam logic [7:0] ALL_ONES     = 8'hFF;
	localparam int         REG_ADDR_W   = 4;
	localparam logic [3:0] ACK_SLOT     = 4'h8;
	localparam logic [3:0] BIT_STEP     = 4'h1;
	localparam logic [3:0] ADDR_STEP    = 4'h1;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int         CLOCK_HZ       = 20_000_000;
	localparam int         SCL_MAX_HZ     = 400_000;
	localparam int         QUARTERS       = 4;
	localparam int         QUARTER_CYCLES = (CLOCK_HZ + QUARTERS * SCL_MAX_HZ - 1) / (QUARTERS * SCL_MAX_HZ);
	localparam int         TIMEOUT_S      = 1;
	// ticks of the 1 Hz timebase after the address: fires between 1 s and 2 s
	localparam logic [1:0] TIMEOUT_TICKS  = 2'(TIMEOUT_S + 1);
	localparam logic [1:0] TICK_STEP      = 2'h1;

	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	// nine target states need a four-bit code
	typedef enum logic [3:0] {
		TS_IDLE, TS_ADDR, TS_REG, TS_WRITE, TS_SACK, TS_TX, TS_MACK, TS_DONE, TS_LOCKED
	} target_state_t;

	typedef enum logic [2:0] {
		HS_IDLE, HS_START, HS_BIT, HS_STOP, HS_HOLD
	} host_state_t;

endpackage

// ---- logic/rtc_i2c_link_if.sv ----
// the two bus wires between controller and clock target, with pull-ups
// assumes: open-drain drivers only; a released wire reads high
`timescale 1ns/1ps
interface rtc_i2c_link_if;
	logic host_scl_out;
	logic host_scl_oe;
	logic host_sda_out;
	logic host_sda_oe;
	logic dev_sda_out;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// ----------------------------------------------------------------
	// wired-and resolution
	// ----------------------------------------------------------------
	assign scl = host_scl_oe ? host_scl_out : 1'b1;
	assign sda = (host_sda_oe ? host_sda_out : 1'b1) & (dev_sda_oe ? dev_sda_out : 1'b1);

	modport host (
		output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe,
		input  scl, sda
	);
	modport target (
		output dev_sda_out, dev_sda_oe,
		input  scl, sda
	);
endinterface // rtc_i2c_link_if

// ---- logic/rtc_i2c_host.sv ----
// bus controller end: byte commands in, start/bytes/ack/stop on the wires
// assumes: sole controller on the bus; target never stretches the clock
`timescale 1ns/1ps
module rtc_i2c_host (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// command
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic        cmd_start,
	input  wire logic        cmd_stop,
	input  wire logic        cmd_read,
	input  wire logic        cmd_nack,
	input  wire logic [7:0]  cmd_data,
	// answer
	output logic             rsp_valid,
	output logic [7:0]       rsp_data,
	output logic             rsp_no_ack,
	// bus
	rtc_i2c_link_if.host     bus
);
	import rtc_i2c_pkg::*;

	localparam logic [5:0] QUARTER_LAST = 6'(QUARTER_CYCLES - 1);

	host_state_t state_q;
	logic [5:0]  qcnt_q;
	logic [1:0]  phase_q;
	logic [3:0]  bit_q;
	logic [7:0]  sh_q;
	logic [7:0]  rx_q;
	logic        read_q;
	logic        nack_q;
	logic        stop_q;
	logic        scl_oe_q;
	logic        sda_oe_q;
	logic        scl_meta_q;
	logic        scl_sync_q;
	logic        sda_meta_q;
	logic        sda_sync_q;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire qtick    = (qcnt_q == 6'h00);
	wire take     = cmd_valid & cmd_ready;
	wire data_bit = (bit_q != ACK_SLOT);
	// a new transfer only on a quiet bus or on a bus this end holds
	wire bus_free = scl_sync_q & sda_sync_q;
	wire ack_drv  = read_q & ~nack_q;

	assign bus.host_scl_out = 1'b0;
	assign bus.host_sda_out = 1'b0;
	assign bus.host_scl_oe  = scl_oe_q;
	assign bus.host_sda_oe  = sda_oe_q;

	// ----------------------------------------------------------------
	// line synchronisers and quarter-period divider
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{scl_meta_q, scl_sync_q, sda_meta_q, sda_sync_q} <= 4'hF;
			qcnt_q <= QUARTER_LAST;
		end else begin
			scl_meta_q <= bus.scl;
			scl_sync_q <= scl_meta_q;
			sda_meta_q <= bus.sda;
			sda_sync_q <= sda_meta_q;
			// quarter count rounded up keeps the clock at or below the fast limit
			qcnt_q     <= qtick ? QUARTER_LAST : 6'(qcnt_q - 6'h01);
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q    <= HS_IDLE;
			phase_q    <= 2'h0;
			bit_q      <= 4'h0;
			sh_q       <= 8'h00;
			rx_q       <= 8'h00;
			{read_q, nack_q, stop_q} <= 3'h0;
			scl_oe_q   <= 1'b0;
			sda_oe_q   <= 1'b0;
			cmd_ready  <= 1'b0;
			rsp_valid  <= 1'b0;
			rsp_data   <= 8'h00;
			rsp_no_ack <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			unique case (state_q)
				HS_IDLE, HS_HOLD: begin
					if (state_q == HS_IDLE)
						cmd_ready <= bus_free & ~take;
					if (take) begin
						cmd_ready <= 1'b0;
						{read_q, nack_q, stop_q} <= {cmd_read, cmd_nack, cmd_stop};
						sh_q    <= cmd_read ? ALL_ONES : cmd_data;
						bit_q   <= 4'h0;
						phase_q <= 2'h0;
						// from idle every transfer opens with a start
						state_q <= (cmd_start || state_q == HS_IDLE) ? HS_START : HS_BIT;
					end
				end
				HS_START: if (qtick) begin
					phase_q <= 2'(phase_q + 2'h1);
					unique case (phase_q)
						2'h0: sda_oe_q <= 1'b0;
						2'h1: scl_oe_q <= 1'b0;
						2'h2: sda_oe_q <= 1'b1;
						2'h3: begin
							scl_oe_q <= 1'b1;
							state_q  <= HS_BIT;
						end
					endcase
				end
				HS_BIT: if (qtick) begin
					phase_q <= 2'(phase_q + 2'h1);
					unique case (phase_q)
						// data moves only while the clock is low
						2'h0: sda_oe_q <= data_bit ? ~sh_q[7] : ack_drv;
						2'h1: scl_oe_q <= 1'b0;
						2'h2: begin
							if (data_bit) begin
								rx_q <= {rx_q[6:0], sda_sync_q};
								sh_q <= {sh_q[6:0], 1'b1};
							end else begin
								rsp_no_ack <= sda_sync_q;
							end
						end
						2'h3: begin
							scl_oe_q <= 1'b1;
							if (data_bit) begin
								bit_q <= 4'(bit_q + BIT_STEP);
							end else begin
								sda_oe_q  <= 1'b0;
								rsp_valid <= 1'b1;
								rsp_data  <= rx_q;
								state_q   <= stop_q ? HS_STOP : HS_HOLD;
								cmd_ready <= ~stop_q;
							end
						end
					endcase
				end
				HS_STOP: if (qtick) begin
					phase_q <= 2'(phase_q + 2'h1);
					unique case (phase_q)
						2'h0: sda_oe_q <= 1'b1;
						2'h1: scl_oe_q <= 1'b0;
						2'h2: sda_oe_q <= 1'b0;
						// both wires left released afterwards
						2'h3: state_q <= HS_IDLE;
					endcase
				end
			endcase
		end
	end
endmodule // rtc_i2c_host

// ---- logic/rtc_i2c_target_port.sv ----
// clock module's two-wire target port: address match, register access, timeout
// assumes: oversampling link clock much faster than the bus clock;
// rd_data follows reg_addr within one link clock; tick_1hz from the timebase
`timescale 1ns/1ps
module rtc_i2c_target_port (
	// link clock and reset
	input  wire logic                                 link_clock,
	input  wire logic                                 link_rst_n,
	// timebase
	input  wire logic                                 tick_1hz,
	// register side
	output logic [rtc_i2c_pkg::REG_ADDR_W-1:0]        reg_addr,
	output logic                                      wr_strobe,
	output logic [7:0]                                wr_data,
	output logic                                      rd_strobe,
	input  wire logic [7:0]                           rd_data,
	// time circuits
	output logic                                      freeze,
	// bus
	rtc_i2c_link_if.target                            bus
);
	import rtc_i2c_pkg::*;

	target_state_t                 state_q;
	target_state_t                 state_d;
	target_state_t                 next_q;
	target_state_t                 next_d;
	logic [3:0]                    cnt_q;
	logic [3:0]                    cnt_d;
	logic [7:0]                    shift_q;
	logic [7:0]                    shift_d;
	logic                          oe_q;
	logic                          oe_d;
	logic                          out_q;
	logic                          acked_q;
	logic                          acked_d;
	logic [REG_ADDR_W-1:0]         addr_d;
	logic                          wr_d;
	logic [7:0]                    wdata_d;
	logic                          rd_d;
	logic                          freeze_d;
	logic [1:0]                    tmo_q;
	logic [1:0]                    tmo_d;
	logic                          scl_meta_q;
	logic                          scl_sync_q;
	logic                          scl_prev_q;
	logic                          sda_meta_q;
	logic                          sda_sync_q;
	logic                          sda_prev_q;
	logic                          tick_meta_q;
	logic                          tick_sync_q;
	logic                          tick_prev_q;

	// ----------------------------------------------------------------
	// bus events
	// ----------------------------------------------------------------
	wire scl_rise   = scl_sync_q & ~scl_prev_q;
	wire scl_fall   = ~scl_sync_q & scl_prev_q;
	wire scl_high   = scl_sync_q & scl_prev_q;
	wire start_seen = scl_high & sda_prev_q & ~sda_sync_q;
	wire stop_seen  = scl_high & ~sda_prev_q & sda_sync_q;
	wire tick_rise  = tick_sync_q & ~tick_prev_q;
	wire byte_full  = (cnt_q == ACK_SLOT);
	wire addr_hit   = (shift_q[7:1] == TARGET_ADDR);
	wire receiving  = (state_q == TS_ADDR) || (state_q == TS_REG) || (state_q == TS_WRITE);
	// counted on the device timebase, restarted by every valid address
	wire timed_out  = freeze & tick_rise & (tmo_q == TIMEOUT_TICKS - TICK_STEP);
	wire addr_moved = wr_strobe | rd_strobe;

	// only pull-down on data; the clock wire has no driver here
	assign bus.dev_sda_out = out_q;
	assign bus.dev_sda_oe  = oe_q;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d  = state_q;
		next_d   = next_q;
		cnt_d    = cnt_q;
		shift_d  = shift_q;
		oe_d     = oe_q;
		acked_d  = acked_q;
		// address steps once after every data byte written, and once as each read byte is loaded
		addr_d   = addr_moved ? REG_ADDR_W'(reg_addr + ADDR_STEP) : reg_addr;
		wr_d     = 1'b0;
		wdata_d  = wr_data;
		rd_d     = 1'b0;
		freeze_d = freeze;
		tmo_d    = (tick_rise & freeze) ? 2'(tmo_q + TICK_STEP) : tmo_q;
		if (start_seen) begin
			// a repeated start ends the old transfer just like a stop
			state_d  = TS_ADDR;
			cnt_d    = 4'h0;
			oe_d     = 1'b0;
			freeze_d = 1'b0;
		end else if (stop_seen) begin
			state_d  = TS_IDLE;
			oe_d     = 1'b0;
			freeze_d = 1'b0;
		end else if (timed_out) begin
			// released line reads as all ones; no write strobe can follow
			state_d  = TS_LOCKED;
			oe_d     = 1'b0;
			freeze_d = 1'b0;
		end else if (scl_rise) begin
			if (receiving && !byte_full) begin
				shift_d = {shift_q[6:0], sda_sync_q};
				cnt_d   = 4'(cnt_q + BIT_STEP);
			end else if (state_q == TS_TX) begin
				cnt_d   = 4'(cnt_q + BIT_STEP);
			end else if (state_q == TS_MACK) begin
				acked_d = ~sda_sync_q;
			end
		end else if (scl_fall) begin
			unique case (state_q)
				TS_ADDR: if (byte_full) begin
					if (addr_hit) begin
						state_d  = TS_SACK;
						oe_d     = 1'b1;
						// low bit picks register read or register write
						next_d   = shift_q[0] ? TS_TX : TS_REG;
						freeze_d = 1'b1;
						tmo_d    = 2'h0;
					end else begin
						state_d  = TS_IDLE;
					end
				end
				TS_REG: if (byte_full) begin
					addr_d  = shift_q[REG_ADDR_W-1:0];
					state_d = TS_SACK;
					oe_d    = 1'b1;
					next_d  = TS_WRITE;
				end
				TS_WRITE: if (byte_full) begin
					wr_d    = 1'b1;
					wdata_d = shift_q;
					state_d = TS_SACK;
					oe_d    = 1'b1;
				end
				TS_SACK: begin
					oe_d    = 1'b0;
					cnt_d   = 4'h0;
					state_d = next_q;
					if (next_q == TS_TX) begin
						shift_d = rd_data;
						oe_d    = ~rd_data[7];
						rd_d    = 1'b1;
					end
				end
				TS_TX: begin
					if (byte_full) begin
						oe_d    = 1'b0;
						state_d = TS_MACK;
					end else begin
						// next bit set up while the clock is low
						shift_d = {shift_q[6:0], 1'b1};
						oe_d    = ~shift_q[6];
					end
				end
				TS_MACK: begin
					cnt_d = 4'h0;
					if (acked_q) begin
						state_d = TS_TX;
						shift_d = rd_data;
						oe_d    = ~rd_data[7];
						rd_d    = 1'b1;
					end else begin
						// no acknowledge: leave the line high for the stop
						state_d = TS_DONE;
					end
				end
				TS_IDLE, TS_DONE, TS_LOCKED: begin
					state_d = state_q;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	// inputs are asynchronous to the link clock; edges taken after two flops
	always_ff @(posedge link_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			{scl_meta_q, scl_sync_q, scl_prev_q} <= 3'h7;
			{sda_meta_q, sda_sync_q, sda_prev_q} <= 3'h7;
			{tick_meta_q, tick_sync_q, tick_prev_q} <= 3'h0;
		end else begin
			scl_meta_q  <= bus.scl;
			scl_sync_q  <= scl_meta_q;
			scl_prev_q  <= scl_sync_q;
			sda_meta_q  <= bus.sda;
			sda_sync_q  <= sda_meta_q;
			sda_prev_q  <= sda_sync_q;
			tick_meta_q <= tick_1hz;
			tick_sync_q <= tick_meta_q;
			tick_prev_q <= tick_sync_q;
		end
	end

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	always_ff @(posedge link_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state_q   <= TS_IDLE;
			next_q    <= TS_REG;
			cnt_q     <= 4'h0;
			shift_q   <= 8'h00;
			oe_q      <= 1'b0;
			out_q     <= 1'b0;
			acked_q   <= 1'b0;
			reg_addr  <= '0;
			wr_strobe <= 1'b0;
			wr_data   <= 8'h00;
			rd_strobe <= 1'b0;
			freeze    <= 1'b0;
			tmo_q     <= 2'h0;
		end else begin
			state_q   <= state_d;
			next_q    <= next_d;
			cnt_q     <= cnt_d;
			shift_q   <= shift_d;
			oe_q      <= oe_d;
			out_q     <= 1'b0;
			acked_q   <= acked_d;
			reg_addr  <= addr_d;
			wr_strobe <= wr_d;
			wr_data   <= wdata_d;
			rd_strobe <= rd_d;
			freeze    <= freeze_d;
			tmo_q     <= tmo_d;
		end
	end
endmodule // rtc_i2c_target_port

// ---- sim/rtc_i2c_target_port_asserts.sv ----
// wire-level checks for the controller/target link
// assumes: instantiated beside the link interface, signals hooked up by name
`timescale 1ns/1ps
module rtc_i2c_target_port_asserts (
	// clocks and resets
	input wire logic clock,
	input wire logic rst_n,
	input wire logic link_clock,
	input wire logic link_rst_n,
	// wires
	input wire logic host_scl_out,
	input wire logic host_scl_oe,
	input wire logic host_sda_out,
	input wire logic host_sda_oe,
	input wire logic dev_sda_out,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic [7:0] low_q;

	// saturating count of low clock cycles, for the fast mode low time
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			low_q <= 8'h00;
		end else begin
			low_q <= scl ? 8'h00 : ((low_q == 8'hFF) ? low_q : low_q + 8'h01);
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_dev_open_drain;
		@(posedge link_clock) disable iff (!link_rst_n) dev_sda_oe |-> !dev_sda_out;
	endproperty
	a_dev_open_drain: assert property (p_dev_open_drain) else $error("target drives data high");
	property p_host_open_drain;
		@(posedge clock) disable iff (!rst_n) (host_sda_oe |-> !host_sda_out) and (host_scl_oe |-> !host_scl_out);
	endproperty
	a_host_open_drain: assert property (p_host_open_drain) else $error("controller drives a wire high");
	property p_idle_release;
		@(posedge clock) disable iff (!rst_n) $rose(sda) && scl |=> !host_scl_oe && !host_sda_oe;
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("controller holds a wire after stop");
	property p_dev_steady_high;
		@(posedge link_clock) disable iff (!link_rst_n) scl && $past(scl) |-> $stable(dev_sda_oe);
	endproperty
	a_dev_steady_high: assert property (p_dev_steady_high) else $error("target data moved in clock high");
	property p_dev_rise_low;
		@(posedge link_clock) disable iff (!link_rst_n) $rose(dev_sda_oe) |-> !scl;
	endproperty
	a_dev_rise_low: assert property (p_dev_rise_low) else $error("target pulled data in clock high");
	property p_dev_fall_low;
		@(posedge link_clock) disable iff (!link_rst_n) $fell(dev_sda_oe) |-> !scl;
	endproperty
	a_dev_fall_low: assert property (p_dev_fall_low) else $error("target released data in clock high");
	property p_ack_hold;
		@(posedge link_clock) disable iff (!link_rst_n) $rose(dev_sda_oe) |-> dev_sda_oe [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("target pull too short");
	property p_start_by_host;
		@(posedge link_clock) disable iff (!link_rst_n) $fell(sda) && scl |-> host_sda_oe;
	endproperty
	a_start_by_host: assert property (p_start_by_host) else $error("start made by target");
	property p_stop_release;
		@(posedge link_clock) disable iff (!link_rst_n) $rose(sda) && scl |=> !dev_sda_oe [*8];
	endproperty
	a_stop_release: assert property (p_stop_release) else $error("target pulls data after stop");
	property p_scl_high_min;
		@(posedge clock) disable iff (!rst_n) $rose(scl) |-> scl [*8];
	endproperty
	a_scl_high_min: assert property (p_scl_high_min) else $error("clock high phase too short");
	property p_scl_low_min;
		@(posedge clock) disable iff (!rst_n) $rose(scl) |-> low_q >= 8'h18;
	endproperty
	a_scl_low_min: assert property (p_scl_low_min) else $error("clock low phase too short");
endmodule // rtc_i2c_target_port_asserts

// ---- sim/tb_rtc_i2c_target_port.sv ----
// self-checking bench: controller end and clock target joined on one link
// assumes: package, interface, both ends and the checker compiled first
`timescale 1ns/1ps
module tb_rtc_i2c_target_port;
	import rtc_i2c_pkg::*;
	localparam int LIMIT = 60000;
	logic                  clock, rst_n, link_clock, link_rst_n, tick_1hz;
	logic                  cmd_valid, cmd_ready, cmd_start, cmd_stop, cmd_read, cmd_nack;
	logic [7:0]            cmd_data, rsp_data, wr_data, rd_data, q;
	logic                  rsp_valid, rsp_no_ack, wr_strobe, rd_strobe, freeze, na;
	logic [REG_ADDR_W-1:0] reg_addr;
	logic [7:0]            regs [16];
	logic [8:0]            wire_q;
	int                    num_errors, checks, cycles, reads;

	rtc_i2c_link_if link ();
	rtc_i2c_host i_rtc_i2c_host (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_nack(cmd_nack), .cmd_data(cmd_data),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_no_ack(rsp_no_ack), .bus(link.host));
	rtc_i2c_target_port i_rtc_i2c_target_port (.link_clock(link_clock), .link_rst_n(link_rst_n),
		.tick_1hz(tick_1hz), .reg_addr(reg_addr), .wr_strobe(wr_strobe), .wr_data(wr_data),
		.rd_strobe(rd_strobe), .rd_data(rd_data), .freeze(freeze), .bus(link.target));
	rtc_i2c_target_port_asserts i_rtc_i2c_target_port_asserts (.clock(clock), .rst_n(rst_n),
		.link_clock(link_clock), .link_rst_n(link_rst_n), .host_scl_out(link.host_scl_out),
		.host_scl_oe(link.host_scl_oe), .host_sda_out(link.host_sda_out), .host_sda_oe(link.host_sda_oe),
		.dev_sda_out(link.dev_sda_out), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));

	// ----------------------------------------------------------------
	// register file and wire monitor
	// ----------------------------------------------------------------
	assign rd_data = regs[reg_addr];
	always @(posedge link_clock) begin
		if (wr_strobe === 1'b1) begin
			regs[reg_addr] <= wr_data;
		end
		if (rd_strobe === 1'b1) begin
			reads <= reads + 1;
		end
	end
	always @(posedge link.scl) begin
		wire_q <= {wire_q[7:0], link.sda};
	end
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		link_clock = 1'b0;
		#1.7;
		forever #3 link_clock = ~link_clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			num_errors++;
			$display("CHECK FAILED at %0t: run timed out", $time);
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk1(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h", $time, what, got);
		end
	endtask
	task automatic xfer(input logic s, input logic p, input logic r, input logic n, input logic [7:0] d);
		int k;
		k = 0;
		cmd_valid <= 1'b1;
		cmd_start <= s;
		cmd_stop <= p;
		cmd_read <= r;
		cmd_nack <= n;
		cmd_data <= d;
		do @(posedge clock); while (cmd_ready !== 1'b1 && ++k < 5000);
		cmd_valid <= 1'b0;
		do @(posedge clock); while (rsp_valid !== 1'b1 && ++k < 5000);
		q = rsp_data;
		na = rsp_no_ack;
		if (k >= 5000) begin
			num_errors++;
			$display("CHECK FAILED at %0t: controller gave no answer", $time);
		end
	endtask
	// stop needs the bus free before the link sees it; allow sync latency
	task automatic settle();
		int k;
		k = 0;
		do @(posedge clock); while (cmd_ready !== 1'b1 && ++k < 2000);
		if (k >= 2000) begin
			num_errors++;
			$display("CHECK FAILED at %0t: bus never came free", $time);
		end
		repeat (2) @(posedge clock);
	endtask
	task automatic tick();
		tick_1hz <= 1'b1;
		repeat (3) @(posedge clock);
		tick_1hz <= 1'b0;
		repeat (3) @(posedge clock);
	endtask
	task automatic t_write();
		xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA2);
		chk1(na, 1'b0, "write address ack");
		chk8(wire_q[8:1], 8'hA2, "wire bit order");
		chk1(wire_q[0], 1'b0, "wire ack level");
		chk1(freeze, 1'b1, "freeze set");
		xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'hF3);
		xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h5A);
		chk1(freeze, 1'b1, "short transfer kept");
		xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'hA5);
		settle();
		chk8(regs[3], 8'h5A, "low address bits");
		chk8(regs[4], 8'hA5, "write advance");
		chk1(freeze, 1'b0, "freeze after stop");
		chk1(link.sda & link.scl, 1'b1, "idle wires");
	endtask
	task automatic t_read();
		reads = 0;
		xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA2);
		xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h03);
		xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA3);
		chk1(na, 1'b0, "read address after restart");
		xfer(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
		chk8(q, 8'h5A, "first read byte");
		xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
		chk8(q, 8'hA5, "read advance");
		settle();
		chk8({4'h0, reg_addr}, 8'h05, "address after nack");
		chk8(8'(reads), 8'h02, "one load per byte read");
	endtask
	task automatic t_foreign();
		logic [7:0] addrs [3];
		addrs = '{8'hA0, 8'hB2, 8'h22};
		foreach (addrs[i]) begin
			xfer(1'b1, 1'b1, 1'b0, 1'b0, addrs[i]);
			settle();
			chk1(na, 1'b1, "foreign address");
			chk1(freeze, 1'b0, "foreign freeze");
		end
	endtask
	task automatic t_timeout();
		reads = 0;
		xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA2);
		xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h07);
		tick();
		chk1(freeze, 1'b1, "held after one tick");
		tick();
		chk1(freeze, 1'b0, "cleared after two ticks");
		xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h77);
		chk1(na, 1'b1, "ignored until start");
		xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
		chk8(q, 8'hFF, "read after clearing");
		settle();
		chk8(regs[7], 8'h00, "write dropped");
		chk8(8'(reads), 8'h00, "no load while cleared");
		xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'hA2);
		chk1(na, 1'b0, "new start answered");
		settle();
	endtask
	task automatic wrap_up();
		if (num_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		foreach (regs[i]) regs[i] = 8'h00;
		{num_errors, checks, cycles, reads} = '0;
		{rst_n, link_rst_n, tick_1hz, cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nack} = '0;
		cmd_data = 8'h00;
		repeat (2) @(posedge clock);
		chk1(freeze, 1'b0, "freeze in reset");
		chk8({4'h0, reg_addr}, 8'h00, "address in reset");
		rst_n <= 1'b1;
		link_rst_n <= 1'b1;
		settle();
		t_write();
		t_read();
		t_foreign();
		t_timeout();
		wrap_up();
	end
endmodule // tb_rtc_i2c_target_port
